// file: src/oscss_pkg.sv
// Shared constants for the oscillator and system clock source selector
package oscss_pkg;

  // ==========================================================================
  // Register port shape
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 8;

  // ==========================================================================
  // Register offsets
  localparam logic [3:0] OFF_SYS_MODE = 4'h0;   // system_mode_register
  localparam logic [3:0] OFF_SUB_SEL  = 4'h1;   // sub_clock_select_register
  localparam logic [3:0] OFF_STATUS   = 4'h2;   // read-only state view

  // ==========================================================================
  // system_mode_register fields
  localparam int unsigned SYSTEM_MODE_REGISTER_HL_BIT   = 0;    // high_low_clock_select, 1 = fast
  localparam int unsigned SYSTEM_MODE_REGISTER_IDLE_BIT = 1;    // Halt goes to idle, not sleep
  localparam int unsigned SYSTEM_MODE_REGISTER_CKS_LSB  = 5;    // clock_divider_select, 3 bits
  localparam logic [7:0]  SYSTEM_MODE_REGISTER_WMASK    = 8'he3;
  localparam logic [7:0]  SYSTEM_MODE_REGISTER_RESET    = 8'h01;

  // ==========================================================================
  // sub_clock_select_register fields
  localparam int unsigned SUB_LP_BIT    = 7;    // slow_crystal_low_power
  localparam logic [6:0]  SUB_CODE_INTERNAL_SLOW_RC = 7'h2a; // 0101010
  localparam logic [6:0]  SUB_CODE_LXT  = 7'h55; // 1010101
  localparam logic [7:0]  SUB_RESET     = 8'h2a;

  // ==========================================================================
  // Status fields
  localparam int unsigned ST_LXT_READY = 0;
  localparam int unsigned ST_ON_FAST   = 1;
  localparam int unsigned ST_FAST_RUN  = 2;
  localparam int unsigned ST_HALTED    = 3;
  localparam int unsigned ST_CFG_XTAL  = 4;
  localparam int unsigned ST_CFG_HF    = 5;

  // ==========================================================================
  // Oscillator figures and timing counts
  localparam int unsigned FAST_RC_KHZ     = 8000;
  localparam int unsigned SLOW_RC_KHZ     = 32;
  localparam int unsigned DIV_MAX_LOG2    = 6;    // Fast divider up to 64
  localparam int unsigned LXT_START_TICKS = 1024; // Crystal edges before use

  // ==========================================================================
  // Operating modes
  typedef enum logic [1:0] {
    MODE_NORMAL,
    MODE_SLOW,
    MODE_IDLE,
    MODE_SLEEP
  } oscss_mode_t;

endpackage

// file: src/oscss_tick_divider.sv
// Power-of-two divider of an enable pulse train
`timescale 1ns/1ps
`default_nettype none
module oscss_tick_divider
  import oscss_pkg::*;
#(
  parameter int unsigned CNT_W = DIV_MAX_LOG2
) (
  input  wire logic             core_clk,
  input  wire logic             sys_rst,
  input  wire logic             tick_in,
  input  wire logic [2:0]       ratio_sel,
  input  wire logic             clear,
  output logic                  tick_out
);

  // ==========================================================================
  // Ratio decode: 2**sel, clamped at the largest ratio
  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] mask;
  logic [2:0]       sel_clamped;

  assign sel_clamped = (ratio_sel > 3'(CNT_W)) ? 3'(CNT_W) : ratio_sel;
  assign mask        = CNT_W'((1 << sel_clamped) - 1);
  assign tick_out    = tick_in && ((count & mask) == mask);

  // Clear restarts the period so a new ratio never yields a short pulse
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      count <= '0;
    end else if (clear) begin
      count <= '0;
    end else if (tick_in) begin
      count <= count + 1'b1;
    end
  end

endmodule
`default_nettype wire

// file: src/oscss_top.sv
// Oscillator source selection, fast clock divider and system clock gating
//
// Implementation choices: the address map and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module oscss_top
  import oscss_pkg::*;
#(
  parameter int unsigned LXT_START = LXT_START_TICKS
) (
  input  wire logic              core_clk,
  input  wire logic              sys_rst,
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [DATA_W-1:0] reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [DATA_W-1:0] reg_rdata,
  input  wire logic              cfg_fast_crystal,
  input  wire logic              cfg_crystal_high_freq,
  input  wire logic              internal_fast_rc_tick,
  input  wire logic              external_fast_crystal_tick,
  input  wire logic              internal_slow_rc_tick,
  input  wire logic              external_slow_crystal_tick,
  input  wire logic              cpu_halt,
  input  wire logic              wdt_enable,
  output logic                   sys_clk_en,
  output logic                   wdt_clk_en,
  output logic                   tbc_clk_en,
  output logic                   fast_osc_run,
  output logic                   slow_crystal_run,
  output logic                   fast_crystal_high_freq,
  output logic                   slow_crystal_low_power,
  output logic                   fast_crystal_pins_io,
  output logic                   slow_crystal_pins_io,
  output logic                   mcu_reset_req
);

  // ==========================================================================
  // Configuration options
  // Options are straps: caught once by a clocked process after reset release
  logic cfg_taken;
  logic cfg_xtal_q;
  logic cfg_hf_q;

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cfg_taken  <= 1'b0;
      cfg_xtal_q <= 1'b0;
      cfg_hf_q   <= 1'b0;
    end else if (!cfg_taken) begin
      cfg_taken  <= 1'b1;
      cfg_xtal_q <= cfg_fast_crystal;
      cfg_hf_q   <= cfg_crystal_high_freq;
    end
  end

  // ==========================================================================
  // Register decode
  logic [7:0] sys_mode;
  logic [7:0] sub_sel;
  wire        wr_sys_mode = reg_wr && (reg_addr == OFF_SYS_MODE);
  wire        wr_sub_sel  = reg_wr && (reg_addr == OFF_SUB_SEL);
  wire  [6:0] new_code    = reg_wdata[6:0];
  // Only two codes are legal; anything else asks for a device reset
  wire        code_bad    = (new_code != SUB_CODE_INTERNAL_SLOW_RC) && (new_code != SUB_CODE_LXT);

  // Sub select holds its old legal value on a bad code, so a slow source
  // always stays designated even before the reset lands
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sys_mode      <= SYSTEM_MODE_REGISTER_RESET;
      sub_sel       <= SUB_RESET;
      mcu_reset_req <= 1'b0;
    end else begin
      mcu_reset_req <= wr_sub_sel && code_bad;
      if (wr_sys_mode) begin
        sys_mode <= reg_wdata & SYSTEM_MODE_REGISTER_WMASK;
      end
      if (wr_sub_sel && !code_bad) begin
        sub_sel <= reg_wdata;
      end
    end
  end

  // ==========================================================================
  // Slow source selection and crystal start-up
  wire        sel_lxt = (sub_sel[6:0] == SUB_CODE_LXT);
  logic [15:0] lxt_count;
  logic        lxt_ready;

  // The crystal counts its own edges; a stopped crystal starts over
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      lxt_count <= '0;
      lxt_ready <= 1'b0;
    end else if (!slow_crystal_run) begin
      lxt_count <= '0;
      lxt_ready <= 1'b0;
    end else if (external_slow_crystal_tick && !lxt_ready) begin
      lxt_count <= lxt_count + 16'h0001;
      lxt_ready <= (lxt_count == 16'(LXT_START - 1));
    end
  end

  // Slow clock edges: RC or settled crystal, never both; none while the crystal starts up
  wire sub_live = !sel_lxt || lxt_ready;
  wire sub_tick = sel_lxt ? (external_slow_crystal_tick && lxt_ready)
                          : internal_slow_rc_tick;

  // ==========================================================================
  // Fast source and divider
  wire fast_src_tick = (cfg_xtal_q ? external_fast_crystal_tick
                                   : internal_fast_rc_tick) && fast_osc_run;
  logic       on_fast;
  logic [2:0] div_sel;
  logic       div_tick;
  logic       apply_sel;

  oscss_tick_divider #(
    .CNT_W (DIV_MAX_LOG2)
  ) u_fast_div (
    .core_clk  (core_clk),
    .sys_rst   (sys_rst),
    .tick_in   (fast_src_tick),
    .ratio_sel (div_sel),
    .clear     (apply_sel),
    .tick_out  (div_tick)
  );

  // ==========================================================================
  // Glitch-free switching
  // A new source or ratio takes over at an edge of the present one, or at once from an unsettled slow crystal
  wire       want_fast = sys_mode[SYSTEM_MODE_REGISTER_HL_BIT];
  wire [2:0] want_div  = sys_mode[SYSTEM_MODE_REGISTER_CKS_LSB +: 3];
  wire       raw_tick  = on_fast ? div_tick : sub_tick;
  wire       sel_moved = (want_fast != on_fast) || (want_div != div_sel);
  // A dead slow crystal would never give its edge, so it may be left at once
  assign apply_sel = sel_moved && (raw_tick || (!on_fast && !sub_live));

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      on_fast <= SYSTEM_MODE_REGISTER_RESET[SYSTEM_MODE_REGISTER_HL_BIT];
      div_sel <= SYSTEM_MODE_REGISTER_RESET[SYSTEM_MODE_REGISTER_CKS_LSB +: 3];
    end else if (apply_sel) begin
      on_fast <= want_fast;
      div_sel <= want_div;
    end
  end

  // ==========================================================================
  // Operating mode
  oscss_mode_t mode;
  oscss_mode_t next_mode;

  always_comb begin
    case ({cpu_halt, sys_mode[SYSTEM_MODE_REGISTER_IDLE_BIT]})
      2'b10:   next_mode = MODE_SLEEP;
      2'b11:   next_mode = MODE_IDLE;
      default: next_mode = on_fast ? MODE_NORMAL : MODE_SLOW;
    endcase
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      mode <= MODE_NORMAL;
    end else begin
      mode <= next_mode;
    end
  end

  // ==========================================================================
  // Clock enables to the core and timers
  logic cpu_running;
  logic wdt_keep;
  logic tbc_keep;

  always_comb begin
    case (mode)
      MODE_NORMAL: begin
        cpu_running = 1'b1;
        wdt_keep    = 1'b1;
        tbc_keep    = 1'b1;
      end
      MODE_SLOW: begin
        cpu_running = 1'b1;
        wdt_keep    = 1'b1;
        tbc_keep    = 1'b1;
      end
      MODE_IDLE: begin
        cpu_running = 1'b0;
        wdt_keep    = 1'b1;
        tbc_keep    = 1'b1;
      end
      MODE_SLEEP: begin
        cpu_running = 1'b0;
        wdt_keep    = wdt_enable;
        tbc_keep    = 1'b0;
      end
      default: begin
        cpu_running = 1'b0;
        wdt_keep    = 1'b0;
        tbc_keep    = 1'b0;
      end
    endcase
  end

  // Fast oscillator only runs while the core is clocked from it
  wire next_fast_run = (next_mode == MODE_NORMAL);

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sys_clk_en   <= 1'b0;
      wdt_clk_en   <= 1'b0;
      tbc_clk_en   <= 1'b0;
      fast_osc_run <= 1'b1;
    end else begin
      sys_clk_en   <= raw_tick && cpu_running && (next_mode != MODE_IDLE)
                      && (next_mode != MODE_SLEEP);
      wdt_clk_en   <= sub_tick && wdt_keep;
      tbc_clk_en   <= sub_tick && tbc_keep;
      fast_osc_run <= next_fast_run;
    end
  end

  // ==========================================================================
  // Pin function and oscillator control
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      slow_crystal_run       <= 1'b0;
      slow_crystal_low_power <= 1'b0;
      fast_crystal_high_freq <= 1'b0;
      fast_crystal_pins_io   <= 1'b1;
      slow_crystal_pins_io   <= 1'b1;
    end else begin
      slow_crystal_run       <= sel_lxt;
      slow_crystal_low_power <= sub_sel[SUB_LP_BIT];
      fast_crystal_high_freq <= cfg_hf_q;
      fast_crystal_pins_io   <= !cfg_xtal_q;
      slow_crystal_pins_io   <= !sel_lxt;
    end
  end

  // ==========================================================================
  // Read port: data valid only in the cycle after the strobe
  wire [7:0] status_word = {2'b00, cfg_hf_q, cfg_xtal_q, (mode == MODE_IDLE) ||
                            (mode == MODE_SLEEP), fast_osc_run, on_fast, lxt_ready};
  wire [7:0] rd_mux = (reg_addr == OFF_SYS_MODE) ? sys_mode :
                      (reg_addr == OFF_SUB_SEL)  ? sub_sel  :
                      (reg_addr == OFF_STATUS)   ? status_word : 8'h00;

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata <= '0;
    end else begin
      reg_rdata <= reg_rd ? rd_mux : 8'h00;
    end
  end

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  a_bad_code_reset: assert property (
    (wr_sub_sel && code_bad) |=> (mcu_reset_req && $stable(sub_sel)))
    else $error("Bad sub code did not request reset");

  a_slow_pin_use: assert property (
    ##1 (slow_crystal_pins_io == !$past(sel_lxt)))
    else $error("Slow crystal pin function wrong");

  a_fast_pin_use: assert property (
    cfg_taken ##1 1 |-> (fast_crystal_pins_io == !cfg_xtal_q))
    else $error("Fast crystal pin function wrong");

  a_fast_stop_slow: assert property (
    (!on_fast && !cpu_halt) |=> !fast_osc_run)
    else $error("Fast oscillator runs while on slow clock");

  a_halt_stops_sys: assert property (
    cpu_halt |=> !sys_clk_en)
    else $error("System clock ran during halt");

  a_lxt_not_ready: assert property (
    (sel_lxt && !lxt_ready) |=> !wdt_clk_en && !tbc_clk_en)
    else $error("Slow crystal used before start-up");

  a_sys_needs_src: assert property (
    sys_clk_en |-> $past(raw_tick))
    else $error("System clock pulse without source edge");

  a_lp_follows_reg: assert property (
    (wr_sub_sel && !code_bad) |=> ##1 (slow_crystal_low_power == $past(reg_wdata[7], 2)))
    else $error("Low power bit not applied");

  a_div_ratio_max: assert property (
    (on_fast && div_sel == 3'h6 && div_tick) |->
      (u_fast_div.count[5:0] == 6'h3f) ##1 (u_fast_div.count[5:0] == 6'h00))
    else $error("Divide by 64 edge at wrong count");

  a_read_one_cycle: assert property (
    (!reg_rd) |=> (reg_rdata == 8'h00))
    else $error("Read data stood without a read strobe");

  // Idle keeps both timer clocks alive from the slow source
  a_idle_timers_on: assert property (
    (mode == MODE_IDLE && sub_tick) |=> (wdt_clk_en && tbc_clk_en))
    else $error("Timer clocks stopped in idle");

  a_sleep_tbc_off: assert property (
    (mode == MODE_SLEEP) |=> !tbc_clk_en)
    else $error("Time base clock ran in sleep");

  a_lxt_restart: assert property (
    !slow_crystal_run |=> !lxt_ready)
    else $error("Crystal ready without a running crystal");

  a_option_held: assert property (
    cfg_taken |=> ($stable(cfg_xtal_q) && $stable(cfg_hf_q)))
    else $error("Source option changed after capture");

  a_slow_rc_feeds: assert property (
    (!sel_lxt && internal_slow_rc_tick && mode != MODE_SLEEP) |=> wdt_clk_en)
    else $error("Slow RC edge lost to the watchdog");

endmodule
`default_nettype wire

// file: testbench/tb_top.sv
// Self-checking bench for the oscillator source selector
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import oscss_pkg::*;
;
  // ==========================================================================
  // Stimulus and observed signals
  logic              core_clk;
  logic              sys_rst;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata;
  logic              reg_wr;
  logic              reg_rd;
  logic [DATA_W-1:0] reg_rdata;
  logic              cfg_fast_crystal;
  logic              cfg_crystal_high_freq;
  logic              fast_rc_tick;
  logic              fast_xt_tick;
  logic              slow_rc_tick;
  logic              slow_xt_tick;
  logic              cpu_halt;
  logic              wdt_enable;
  logic              sys_clk_en;
  logic              wdt_clk_en;
  logic              tbc_clk_en;
  logic              fast_osc_run;
  logic              slow_crystal_run;
  logic              fast_crystal_high_freq;
  logic              slow_crystal_low_power;
  logic              fast_crystal_pins_io;
  logic              slow_crystal_pins_io;
  logic              mcu_reset_req;
  logic [2:0]        sdiv = 3'h0;
  int                err_total;
  int                checks;

  // ==========================================================================
  // Design under test, crystal start-up shortened to keep the run brief
  oscss_top #(.LXT_START(4)) oscss_top_i (
    .core_clk                   (core_clk),
    .sys_rst                    (sys_rst),
    .reg_addr                   (reg_addr),
    .reg_wdata                  (reg_wdata),
    .reg_wr                     (reg_wr),
    .reg_rd                     (reg_rd),
    .reg_rdata                  (reg_rdata),
    .cfg_fast_crystal           (cfg_fast_crystal),
    .cfg_crystal_high_freq      (cfg_crystal_high_freq),
    .internal_fast_rc_tick      (fast_rc_tick),
    .external_fast_crystal_tick (fast_xt_tick),
    .internal_slow_rc_tick      (slow_rc_tick),
    .external_slow_crystal_tick (slow_xt_tick),
    .cpu_halt                   (cpu_halt),
    .wdt_enable                 (wdt_enable),
    .sys_clk_en                 (sys_clk_en),
    .wdt_clk_en                 (wdt_clk_en),
    .tbc_clk_en                 (tbc_clk_en),
    .fast_osc_run               (fast_osc_run),
    .slow_crystal_run           (slow_crystal_run),
    .fast_crystal_high_freq     (fast_crystal_high_freq),
    .slow_crystal_low_power     (slow_crystal_low_power),
    .fast_crystal_pins_io       (fast_crystal_pins_io),
    .slow_crystal_pins_io       (slow_crystal_pins_io),
    .mcu_reset_req              (mcu_reset_req)
  );

  // ==========================================================================
  // 25 MHz clock
  initial core_clk = 1'b0;
  always #20 core_clk = ~core_clk;

  // Oscillator ticks: fast RC every cycle, fast crystal every other cycle,
  // both slow sources every 8 cycles at different phases
  always @(posedge core_clk) begin
    sdiv         <= sdiv + 3'h1;
    fast_xt_tick <= sdiv[0];
    slow_rc_tick <= (sdiv == 3'h7);
    slow_xt_tick <= (sdiv == 3'h3);
  end

  // ==========================================================================
  // Helpers
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr    <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so sample mid-cycle
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge core_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd   <= 1'b0;
    @(negedge core_clk);
    d = reg_rdata;
  endtask

  task automatic rdchk(input string name, input logic [3:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    chk(name, d, exp);
  endtask

  task automatic do_reset(input logic xt, input logic hf);
    @(posedge core_clk);
    sys_rst               <= 1'b1;
    cfg_fast_crystal      <= xt;
    cfg_crystal_high_freq <= hf;
    repeat (8) @(posedge core_clk);
    sys_rst <= 1'b0;
    repeat (3) @(posedge core_clk);
    // Leave the caller in mid-cycle so outputs are settled when looked at
    @(negedge core_clk);
  endtask

  // Cycles between two system clock pulses; bounded waits guard a dead clock
  task automatic gap(output int g);
    int n;
    n = 0;
    @(negedge core_clk);
    while (sys_clk_en !== 1'b1 && n < 300) begin
      @(negedge core_clk);
      n++;
    end
    @(negedge core_clk);
    g = 1;
    while (sys_clk_en !== 1'b1 && g < 300) begin
      @(negedge core_clk);
      g++;
    end
  endtask

  // Pulses over 64 cycles: a whole number of slow periods, so phase-free
  task automatic count64(output int ns, output int nw, output int nt, output int nr);
    ns = 0; nw = 0; nt = 0; nr = 0;
    repeat (64) begin
      @(negedge core_clk);
      ns += int'(sys_clk_en === 1'b1);
      nw += int'(wdt_clk_en === 1'b1);
      nt += int'(tbc_clk_en === 1'b1);
      nr += int'(mcu_reset_req === 1'b1);
    end
  endtask

  // ==========================================================================
  // Watchdog: the whole sequence needs under two thousand cycles
  initial begin
    repeat (20000) @(posedge core_clk);
    err_total++;
    summarize();
  end

  // ==========================================================================
  // Main sequence
  initial begin
    int g;
    int ns, nw, nt, nr;
    err_total = 0; checks = 0;
    sys_rst = 1'b1; reg_addr = 4'h0; reg_wdata = 8'h00; reg_wr = 1'b0; reg_rd = 1'b0;
    cfg_fast_crystal = 1'b0; cfg_crystal_high_freq = 1'b0;
    fast_rc_tick = 1'b1;
    cpu_halt = 1'b0; wdt_enable = 1'b0;
    do_reset(1'b0, 1'b0);
    // Reset values, register map and refusals
    rdchk("sys_mode", OFF_SYS_MODE, SYSTEM_MODE_REGISTER_RESET);
    rdchk("sub_sel", OFF_SUB_SEL, SUB_RESET);
    rdchk("status", OFF_STATUS, 8'h06);
    chk("fast_pins_io", {7'h0, fast_crystal_pins_io}, 8'h01);
    chk("slow_pins_io", {7'h0, slow_crystal_pins_io}, 8'h01);
    chk("low_power", {7'h0, slow_crystal_low_power}, 8'h00);
    wr(4'hf, 8'h5a);
    rdchk("unmapped", 4'hf, 8'h00);
    wr(OFF_SYS_MODE, 8'hff);
    rdchk("sys_mode_mask", OFF_SYS_MODE, 8'he3);
    wr(OFF_SYS_MODE, SYSTEM_MODE_REGISTER_RESET);
    $display("test registers done");
    // Illegal sub codes are refused with one reset request each
    for (int i = 0; i < 4; i++) begin
      wr(OFF_SUB_SEL, {1'b0, (i == 0) ? 7'h00 : (i == 1) ? 7'h2b : (i == 2) ? 7'h7f : 7'h54});
      count64(ns, nw, nt, nr);
      chk("reset_req_count", 8'(nr), 8'h01);
      rdchk("sub_kept", OFF_SUB_SEL, SUB_RESET);
    end
    $display("test sub code done");
    // Divider ratios on the fast RC, every select value
    for (int s = 0; s < 8; s++) begin
      wr(OFF_SYS_MODE, {3'(s), 5'h01});
      gap(g);
      gap(g);
      chk("fast_ratio", 8'(g), (s >= 6) ? 8'h40 : 8'(1 << s));
    end
    $display("test divider done");
    // Fast to slow on the slow RC: fast oscillator stops
    wr(OFF_SYS_MODE, 8'h00);
    gap(g);
    gap(g);
    chk("slow_rc_period", 8'(g), 8'h08);
    chk("fast_run_off", {7'h0, fast_osc_run}, 8'h00);
    rdchk("status_slow", OFF_STATUS, 8'h00);
    wr(OFF_SYS_MODE, SYSTEM_MODE_REGISTER_RESET);
    // Return to fast waits for a slow edge; let it land before the crystal test
    repeat (12) @(posedge core_clk);
    // Slow crystal: pins taken, start-up delay, then usable as system clock
    wr(OFF_SUB_SEL, {1'b0, SUB_CODE_LXT});
    rdchk("xt_not_ready", OFF_STATUS, 8'h06);
    chk("slow_xt_run", {7'h0, slow_crystal_run}, 8'h01);
    chk("slow_pins_xt", {7'h0, slow_crystal_pins_io}, 8'h00);
    count64(ns, nw, nt, nr);
    rdchk("xt_ready", OFF_STATUS, 8'h07);
    wr(OFF_SUB_SEL, {1'b1, SUB_CODE_LXT});
    rdchk("sub_lp", OFF_SUB_SEL, 8'hd5);
    chk("low_power_on", {7'h0, slow_crystal_low_power}, 8'h01);
    wr(OFF_SYS_MODE, 8'h00);
    gap(g);
    gap(g);
    chk("slow_xt_period", 8'(g), 8'h08);
    wr(OFF_SYS_MODE, SYSTEM_MODE_REGISTER_RESET);
    $display("test sources done");
    // Idle, then sleep with and without watchdog
    wr(OFF_SYS_MODE, 8'h03);
    @(posedge core_clk);
    cpu_halt <= 1'b1;
    repeat (3) @(posedge core_clk);
    count64(ns, nw, nt, nr);
    chk("idle_sys", 8'(ns), 8'h00);
    chk("idle_tbc", 8'(nt), 8'h08);
    chk("idle_wdt", 8'(nw), 8'h08);
    chk("idle_fast_off", {7'h0, fast_osc_run}, 8'h00);
    @(posedge core_clk);
    cpu_halt <= 1'b0;
    wr(OFF_SYS_MODE, SYSTEM_MODE_REGISTER_RESET);
    for (int w = 0; w < 2; w++) begin
      @(posedge core_clk);
      wdt_enable <= w[0];
      cpu_halt   <= 1'b1;
      repeat (3) @(posedge core_clk);
      count64(ns, nw, nt, nr);
      chk("sleep_sys", 8'(ns), 8'h00);
      chk("sleep_tbc", 8'(nt), 8'h00);
      chk("sleep_wdt", 8'(nw), w[0] ? 8'h08 : 8'h00);
      @(posedge core_clk);
      cpu_halt <= 1'b0;
    end
    $display("test low power modes done");
    // Fast crystal chosen by option in a second reset, pins then taken
    do_reset(1'b1, 1'b1);
    chk("fast_pins_xt", {7'h0, fast_crystal_pins_io}, 8'h00);
    chk("fast_hf", {7'h0, fast_crystal_high_freq}, 8'h01);
    rdchk("status_xt", OFF_STATUS, 8'h36);
    gap(g);
    gap(g);
    chk("fast_xt_period", 8'(g), 8'h02);
    do_reset(1'b1, 1'b0);
    chk("fast_lf", {7'h0, fast_crystal_high_freq}, 8'h00);
    rdchk("status_lf", OFF_STATUS, 8'h16);
    $display("test options done");
    summarize();
  end

endmodule
`default_nettype wire
